// ===== hdl/tdc_clock.sv
/*
 Time-of-day clock with BCD calendar and an 8-byte buffer port through
 which a processor core reads and sets the clock.
 Assumes the core keeps the buffer memory and serves byte reads and
 writes in the same cycle they are asked for; addr_bad flags an invalid
 indirect address alongside a request.
*/
// Function
// - A read copies date and time into eight bytes from the base.
// - A set loads the clock from eight bytes from the base.
// - Byte order is year, month, day, hour, minute, second, zero, dow.
// - Day of week runs 1 Sunday to 7 Saturday and 0 disables it.
// - After memory loss the clock restarts at 1 Jan 90 00:00:00 Sunday.
// - Failures clear success and report 0006, 0007 or 000C.
// - Day of week and date are not cross-checked; odd dates pass.
// - A request during a running access is refused, not queued.
// - A refused overlap sets the collision flag and reports 0007.
// - Only the two low decimal digits of the year are kept.
// - The year serves only storage and leap handling.
// - February 29 is inserted in leap years up to 2096.
`include "tdc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tdc_clock import tdc_pkg::*; #(
   parameter int TICK_CYC = `TDC_TICK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Retained memory lost, clock hardware present
   input wire logic mem_lost,
   input wire logic clk_present,
   // Operation request
   input wire tdc_req_type req,
   input wire logic addr_bad,
   // Buffer byte port
   output logic buf_we,
   output logic [15:0] buf_addr,
   output logic [7:0] buf_wdata,
   input wire logic [7:0] buf_rdata,
   // Result
   output tdc_resp_type resp,
   output logic clock_collision_flag,
   output tdc_time_type now
);
   // Tick period must leave room for the counter to wrap
   if (TICK_CYC < 2) begin : g_tick_chk
      $error("TICK_CYC too small");
   end
   // ====================================================
   // Timebase and calendar
   tdc_time_type t_q, t_d, tick_t;
   logic [31:0] tick_cnt_q;
   wire tick = (tick_cnt_q == 32'(TICK_CYC - 1));
   wire c_sec, c_min, c_hour, c_day, c_mon;
   wire [7:0] s_n, m_n, h_n, d_n, mo_n, y_n, w_n;
   // Leap: year BCD divisible by 4 (tens even & ones 0/4/8 or odd & 2/6)
   wire leap = (t_q.year[4] == 1'b0)
      ? (t_q.year[3:0] == 4'h0 || t_q.year[3:0] == 4'h4
         || t_q.year[3:0] == 4'h8)
      : (t_q.year[3:0] == 4'h2 || t_q.year[3:0] == 4'h6);
   wire short_mon = (t_q.month == 8'h04) || (t_q.month == 8'h06)
      || (t_q.month == 8'h09) || (t_q.month == 8'h11);
   wire [7:0] mdays = (t_q.month == 8'h02) ? (leap ? 8'h29 : 8'h28)
      : (short_mon ? 8'h30 : 8'h31);
   // Day past month end (odd loaded dates) still wraps
   wire [7:0] day_top = (t_q.day > mdays) ? t_q.day : mdays;
   tdc_bcd_digit u_sec (.val(t_q.sec), .top(8'h59), .low(8'h00),
      .inc(tick), .nxt(s_n), .carry(c_sec));
   tdc_bcd_digit u_min (.val(t_q.min), .top(8'h59), .low(8'h00),
      .inc(c_sec), .nxt(m_n), .carry(c_min));
   tdc_bcd_digit u_hour (.val(t_q.hour), .top(8'h23), .low(8'h00),
      .inc(c_min), .nxt(h_n), .carry(c_hour));
   tdc_bcd_digit u_day (.val(t_q.day), .top(day_top), .low(8'h01),
      .inc(c_hour), .nxt(d_n), .carry(c_day));
   tdc_bcd_digit u_mon (.val(t_q.month), .top(8'h12), .low(8'h01),
      .inc(c_day), .nxt(mo_n), .carry(c_mon));
   // Year wraps 99 to 00; century left to software
   tdc_bcd_digit u_year (.val(t_q.year), .top(8'h99), .low(8'h00),
      .inc(c_mon), .nxt(y_n), .carry());
   tdc_bcd_digit u_dow (.val(t_q.dow), .top(8'h07), .low(8'h01),
      .inc(c_hour & (t_q.dow != 8'h00)), .nxt(w_n),
      .carry());
   always_comb begin
      tick_t = '{year: y_n, month: mo_n, day: d_n, hour: h_n,
                 min: m_n, sec: s_n, dow: w_n};
   end
   // ====================================================
   // Operation sequencer
   tdc_state_type st_q, st_d;
   logic [2:0] idx_q;
   logic is_wr_q, bad_q;
   logic [15:0] base_q;
   tdc_time_type shadow_q;
   tdc_resp_type resp_q;
   logic coll_q;
   logic [15:0] code_q;
   // Last cycle already reports, so a new request may start there
   wire busy = (st_q == TDC_CHK) || (st_q == TDC_XFER);
   wire any_req = req.rd | req.wr;
   wire refuse = busy & any_req;
   wire accept = !busy & any_req;
   // Byte lane in buffer order
   wire [7:0] rd_byte =
      (idx_q == `TDC_OFS_YEAR) ? t_q.year :
      (idx_q == `TDC_OFS_MONTH) ? t_q.month :
      (idx_q == `TDC_OFS_DAY) ? t_q.day :
      (idx_q == `TDC_OFS_HOUR) ? t_q.hour :
      (idx_q == `TDC_OFS_MIN) ? t_q.min :
      (idx_q == `TDC_OFS_SEC) ? t_q.sec :
      (idx_q == `TDC_OFS_ZERO) ? 8'h00 : t_q.dow;
   // Field range check on set; no date cross
   wire bcd_ok = (buf_rdata[7:4] <= 4'h9) && (buf_rdata[3:0] <= 4'h9);
   wire [7:0] hi_lim =
      (idx_q == `TDC_OFS_YEAR) ? 8'h99 :
      (idx_q == `TDC_OFS_MONTH) ? 8'h12 :
      (idx_q == `TDC_OFS_DAY) ? 8'h31 :
      (idx_q == `TDC_OFS_HOUR) ? 8'h23 :
      (idx_q == `TDC_OFS_ZERO) ? 8'hFF :
      (idx_q == `TDC_OFS_DOW) ? 8'h07 : 8'h59;
   wire lo_bad = ((idx_q == `TDC_OFS_MONTH) || (idx_q == `TDC_OFS_DAY))
      && (buf_rdata == 8'h00);
   wire byte_bad = is_wr_q & (!bcd_ok | (buf_rdata > hi_lim) | lo_bad);
   wire in_xfer = (st_q == TDC_XFER);
   wire load = in_xfer && (idx_q == 3'h7) && is_wr_q && !bad_q
      && !byte_bad;
   assign buf_we = in_xfer & !is_wr_q;
   assign buf_addr = base_q + {13'h0000, idx_q};
   assign buf_wdata = rd_byte;
   always_comb begin
      st_d = st_q;
      case (st_q)
         TDC_IDLE: if (accept) st_d = TDC_CHK;
         TDC_CHK: st_d = bad_q ? TDC_DONE : TDC_XFER;
         TDC_XFER: if (idx_q == 3'h7) st_d = TDC_DONE;
         TDC_DONE: st_d = accept ? TDC_CHK : TDC_IDLE;
         default: st_d = TDC_IDLE;
      endcase
   end
   always_comb begin
      t_d = tick ? tick_t : t_q;
      if (load)
         t_d = '{year: shadow_q.year, month: shadow_q.month,
                 day: shadow_q.day, hour: shadow_q.hour,
                 min: shadow_q.min, sec: shadow_q.sec,
                 dow: buf_rdata};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t_q <= '{year: `TDC_RST_YEAR, month: `TDC_RST_MONTH,
                  day: `TDC_RST_DAY, hour: `TDC_RST_HOUR,
                  min: `TDC_RST_MIN, sec: `TDC_RST_SEC,
                  dow: `TDC_RST_DOW};
         tick_cnt_q <= 32'h00000000;
      end else if (mem_lost) begin
         t_q <= '{year: `TDC_RST_YEAR, month: `TDC_RST_MONTH,
                  day: `TDC_RST_DAY, hour: `TDC_RST_HOUR,
                  min: `TDC_RST_MIN, sec: `TDC_RST_SEC,
                  dow: `TDC_RST_DOW};
         tick_cnt_q <= 32'h00000000;
      end else begin
         t_q <= t_d;
         // A set restarts the running second
         tick_cnt_q <= (tick || load) ? 32'h00000000
            : tick_cnt_q + 32'h00000001;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= TDC_IDLE;
         idx_q <= 3'h0;
         is_wr_q <= 1'b0;
         bad_q <= 1'b0;
         base_q <= 16'h0000;
         shadow_q <= '0;
         resp_q <= '0;
         code_q <= 16'h0000;
         coll_q <= 1'b0;
      end else begin
         st_q <= st_d;
         resp_q.done <= 1'b0;
         if (accept) begin
            is_wr_q <= req.wr;
            base_q <= req.base;
            idx_q <= 3'h0;
            bad_q <= addr_bad | !clk_present;
            code_q <= !clk_present ? `TDC_ERR_NOCLK
               : (addr_bad ? `TDC_ERR_ADDR : `TDC_ERR_NONE);
            coll_q <= 1'b0;
         end
         if (in_xfer) begin
            idx_q <= idx_q + 3'h1;
            case (idx_q)
               `TDC_OFS_YEAR: shadow_q.year <= buf_rdata;
               `TDC_OFS_MONTH: shadow_q.month <= buf_rdata;
               `TDC_OFS_DAY: shadow_q.day <= buf_rdata;
               `TDC_OFS_HOUR: shadow_q.hour <= buf_rdata;
               `TDC_OFS_MIN: shadow_q.min <= buf_rdata;
               `TDC_OFS_SEC: shadow_q.sec <= buf_rdata;
               default: shadow_q.dow <= buf_rdata;
            endcase
            if (byte_bad && !bad_q) begin
               bad_q <= 1'b1;
               code_q <= `TDC_ERR_DATA;
            end
         end
         if (st_q == TDC_DONE) begin
            resp_q.done <= 1'b1;
            resp_q.success <= !bad_q;
            // Own code, so a refusal meanwhile cannot overwrite it
            resp_q.code <= code_q;
         end
         if (refuse) begin
            coll_q <= 1'b1;
            resp_q.done <= 1'b1;
            resp_q.success <= 1'b0;
            resp_q.code <= `TDC_ERR_DATA;
         end
      end
   end
   assign resp = resp_q;
   assign clock_collision_flag = coll_q;
   assign now = t_q;
endmodule : tdc_clock
`default_nettype wire

// ===== hdl/tdc_params.svh
/*
 Constants of the time-of-day clock: buffer offsets, error codes, reset
 date, timing counts. Assumes a 200 MHz core clock.
*/
`ifndef TDC_PARAMS_SVH
`define TDC_PARAMS_SVH
`define TDC_OFS_YEAR 3'h0
`define TDC_OFS_MONTH 3'h1
`define TDC_OFS_DAY 3'h2
`define TDC_OFS_HOUR 3'h3
`define TDC_OFS_MIN 3'h4
`define TDC_OFS_SEC 3'h5
`define TDC_OFS_ZERO 3'h6
`define TDC_OFS_DOW 3'h7
`define TDC_ERR_NONE 16'h0000
`define TDC_ERR_ADDR 16'h0006
`define TDC_ERR_DATA 16'h0007
`define TDC_ERR_NOCLK 16'h000C
`define TDC_RST_YEAR 8'h90
`define TDC_RST_MONTH 8'h01
`define TDC_RST_DAY 8'h01
`define TDC_RST_HOUR 8'h00
`define TDC_RST_MIN 8'h00
`define TDC_RST_SEC 8'h00
`define TDC_RST_DOW 8'h01
`define TDC_CLK_HZ 200000000
`define TDC_TICK_S 1
`define TDC_TICK_CYC (`TDC_CLK_HZ * `TDC_TICK_S)
`endif

// ===== hdl/tdc_pkg.sv
/*
 Types of the time-of-day clock.
 Assumes tdc_params.svh supplies the numeric constants.
*/
package tdc_pkg;
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
      logic [7:0] dow;
   } tdc_time_type;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] base;
   } tdc_req_type;
   typedef struct packed {
      logic done;
      logic success;
      logic [15:0] code;
   } tdc_resp_type;
   typedef enum logic [1:0] {
      TDC_IDLE = 2'b00,
      TDC_CHK = 2'b01,
      TDC_XFER = 2'b11,
      TDC_DONE = 2'b10
   } tdc_state_type;
endpackage : tdc_pkg

// ===== hdl/tdc_bcd_digit.sv
/*
 One BCD counter field with wrap: steps by one when inc is high and
 reports carry on wrap from top to low.
 Assumes a BCD-valid value; only ones digits A to E step as plain binary, F wraps to 0 without carry.
*/
`timescale 1ns/1ps
`default_nettype none
module tdc_bcd_digit (
   // Field value and limits
   input wire logic [7:0] val,
   input wire logic [7:0] top,
   input wire logic [7:0] low,
   // Step
   input wire logic inc,
   output logic [7:0] nxt,
   output logic carry
);
   // ====================================================
   // BCD increment
   wire at_top = (val == top);
   wire lo_nine = (val[3:0] == 4'h9);
   wire [7:0] stepped = lo_nine ? {val[7:4] + 4'h1, 4'h0}
                                : {val[7:4], val[3:0] + 4'h1};
   assign carry = inc & at_top;
   assign nxt = !inc ? val : (at_top ? low : stepped);
endmodule : tdc_bcd_digit
`default_nettype wire

// ===== verif/tdc_core_mem.sv
/* Core buffer model: 256 bytes, same-cycle reads, writes on the clock.
 Assumes the bench preloads and inspects mem directly. */
`timescale 1ns/1ps
`default_nettype none
module tdc_core_mem (
   // Clock
   input wire logic clk,
   // Buffer byte port
   input wire logic buf_we,
   input wire logic [15:0] buf_addr,
   input wire logic [7:0] buf_wdata,
   output logic [7:0] buf_rdata
);
   // ======
   // Memory, preloaded in BCD, one access at a time
   logic [7:0] mem [256];
   assign buf_rdata = mem[buf_addr[7:0]];
   always @(posedge clk) if (buf_we) mem[buf_addr[7:0]] <= buf_wdata;
endmodule : tdc_core_mem
`default_nettype wire

// ===== verif/tdc_clock_asserts.sv
/* Port checks of tdc_clock.
 Assumes binding to tdc_clock with its tick parameter. */
`timescale 1ns/1ps
`default_nettype none
module tdc_clock_asserts import tdc_pkg::*; #(parameter int TICK_CYC = 10) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Inputs and buffer port
   input wire logic mem_lost,
   input wire logic buf_we,
   input wire logic [15:0] buf_addr,
   input wire logic [7:0] buf_wdata,
   // Results
   input wire tdc_resp_type resp,
   input wire logic clock_collision_flag,
   input wire tdc_time_type now
);
   // ======
   // Helpers
   logic [3:0] idx_q;
   tdc_time_type now_q;
   logic [31:0] cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_q <= 4'h0;
         now_q <= '0;
         cnt_q <= 32'h0;
      end else begin
         idx_q <= buf_we ? idx_q + 4'h1 : 4'h0;
         now_q <= now;
         cnt_q <= (mem_lost || now != now_q) ? 32'h0 : cnt_q + 32'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ======
   // Checks
   property p_len; $rose(buf_we) |-> buf_we[*8] ##1 !buf_we; endproperty
   a_len: assert property (p_len) else $error("bad length");
   property p_step; buf_we && idx_q != 4'h0 |->
      buf_addr == $past(buf_addr) + 16'h0001; endproperty
   a_step: assert property (p_step) else $error("bad address");
   property p_year; buf_we && idx_q == 4'h0 |-> buf_wdata == now.year;
   endproperty
   a_year: assert property (p_year) else $error("bad year");
   property p_zero; buf_we && idx_q == 4'h6 |-> buf_wdata == 8'h00;
   endproperty
   a_zero: assert property (p_zero) else $error("bad zero");
   property p_dow; buf_we && idx_q == 4'h7 |-> buf_wdata == now.dow;
   endproperty
   a_dow: assert property (p_dow) else $error("bad dow");
   property p_ok; resp.done && resp.success |-> resp.code == 16'h0000;
   endproperty
   a_ok: assert property (p_ok) else $error("bad ok code");
   property p_fail; resp.done && !resp.success |->
      resp.code inside {16'h0006, 16'h0007, 16'h000C}; endproperty
   a_fail: assert property (p_fail) else $error("bad fail code");
   property p_flag; $rose(clock_collision_flag) |-> resp.code == 16'h0007;
   endproperty
   a_flag: assert property (p_flag) else $error("bad refuse");
   property p_lost; mem_lost ##1 mem_lost |-> now == 56'h90010100000001;
   endproperty
   a_lost: assert property (p_lost) else $error("bad restart");
   property p_tick; cnt_q <= TICK_CYC; endproperty
   a_tick: assert property (p_tick) else $error("no tick");
   c_read: cover property (resp.done && resp.success);
   c_refuse: cover property ($rose(clock_collision_flag));
   c_fail: cover property (resp.done && resp.code == 16'h0007);
endmodule : tdc_clock_asserts
bind tdc_clock tdc_clock_asserts #(.TICK_CYC(TICK_CYC)) u_chk (.clk(clk),
   .rst_n(rst_n), .mem_lost(mem_lost), .buf_we(buf_we),
   .buf_addr(buf_addr), .buf_wdata(buf_wdata), .resp(resp),
   .clock_collision_flag(clock_collision_flag), .now(now));
`default_nettype wire

// ===== verif/tdc_clock_bench.sv
/* Self-checking bench of tdc_clock.
 Assumes a 200 MHz clock and a shortened one-second tick. */
`timescale 1ns/1ps
`default_nettype none
module tdc_clock_bench import tdc_pkg::*;;
   logic clk = 0, rst_n = 0, mem_lost = 1, clk_present = 1, addr_bad = 0;
   tdc_req_type req = '0;
   logic buf_we;
   logic [15:0] buf_addr, b, b2;
   logic [7:0] buf_wdata, buf_rdata;
   tdc_resp_type resp, exp_q[$];
   logic clock_collision_flag;
   tdc_time_type now;
   logic [63:0] v;
   logic [31:0] rs = 32'h00016E2F;
   int err_count = 0, n_tests = 0, cyc = 0;
   logic [111:0] roll [4] = '{
      {56'h99123123595907, 56'h00010100000001},
      {56'h96022823595900, 56'h96022900000000},
      {56'h97022823595903, 56'h97030100000004},
      {56'h00022823595906, 56'h00022900000007}};
   always #2.5 clk = ~clk;
   tdc_clock #(.TICK_CYC(40)) dut (.clk(clk), .rst_n(rst_n),
      .mem_lost(mem_lost), .clk_present(clk_present), .req(req),
      .addr_bad(addr_bad), .buf_we(buf_we), .buf_addr(buf_addr),
      .buf_wdata(buf_wdata), .buf_rdata(buf_rdata), .resp(resp),
      .clock_collision_flag(clock_collision_flag), .now(now));
   tdc_core_mem core (.clk(clk), .buf_we(buf_we), .buf_addr(buf_addr),
      .buf_wdata(buf_wdata), .buf_rdata(buf_rdata));
   // ======
   // Helpers
   function automatic logic [15:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs[15:0] & 16'h00F0;
   endfunction : rnd
   function automatic logic [63:0] get(logic [15:0] a);
      for (int i = 0; i < 8; i++) get[63-8*i -: 8] = core.mem[a[7:0]+i];
   endfunction : get
   task automatic put(logic [15:0] a, logic [55:0] t);
      logic [63:0] w;
      w = {t[55:8], 8'h00, t[7:0]};
      for (int i = 0; i < 8; i++) core.mem[a[7:0]+i] = w[63-8*i -: 8];
   endtask : put
   task automatic chk(logic [63:0] got, logic [63:0] ev);
      n_tests++;
      if (got !== ev) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, ev);
      end
   endtask : chk
   task automatic chk_resp(tdc_resp_type got, tdc_resp_type ev);
      n_tests++;
      if (got !== ev) begin
         err_count++;
         $display("MISMATCH %0t resp %h exp %h", $time, got, ev);
      end
   endtask : chk_resp
   task automatic issue(logic wr, logic [15:0] a, logic bad);
      @(posedge clk);
      req <= '{~wr, wr, a};
      addr_bad <= bad;
      @(posedge clk);
      req <= '0;
      addr_bad <= 1'b0;
   endtask : issue
   task automatic op(logic wr, logic [15:0] a, logic bad, logic [15:0] c);
      exp_q.push_back('{1'b1, c == 16'h0000, c});
      issue(wr, a, bad);
      for (int i = 0; i < 30 && exp_q.size() > 0; i++) @(posedge clk);
   endtask : op
   task automatic tally_and_finish();
      if (exp_q.size() != 0) err_count++;
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   // ======
   // Result watcher and timeout
   always @(negedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 5000) begin
         err_count++;
         tally_and_finish();
      end else if (resp.done === 1'b1) begin
         if (exp_q.size() == 0) chk(64'h1, 64'h0);
         else chk_resp(resp, exp_q.pop_front());
      end
   end
   // ======
   // Scenarios
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      mem_lost <= 1'b0;
      b = rnd();
      op(0, b, 0, 16'h0000);
      chk(get(b), 64'h9001010000000001);
      for (int i = 0; i < 4; i++) begin
         b = rnd();
         put(b, roll[i][111:56]);
         op(1, b, 0, 16'h0000);
         for (int k = 0; k < 99 && now.sec === 8'h59; k++) @(negedge clk);
         chk(64'(now), 64'(roll[i][55:0]));
      end
      b = rnd();
      b2 = b ^ 16'h0080;
      put(b, 56'h99023012303002);
      op(1, b, 0, 16'h0000);
      op(0, b2, 0, 16'h0000);
      v = get(b2);
      chk(v >> 32, 64'h99023012);
      put(b, 56'h99133012303002);
      op(1, b, 0, 16'h0007);
      chk(64'(now.month), 64'h02);
      exp_q.push_back('{1'b1, 1'b0, 16'h0007});
      exp_q.push_back('{1'b1, 1'b1, 16'h0000});
      issue(0, b2, 0);
      issue(0, b, 0);
      for (int i = 0; i < 30 && exp_q.size() > 0; i++) @(posedge clk);
      chk(64'(clock_collision_flag), 64'h1);
      chk(64'(core.mem[b2[7:0]+6]), 64'h0);
      op(0, b, 1, 16'h0006);
      chk(64'(clock_collision_flag), 64'h0);
      mem_lost <= 1'b1;
      repeat (2) @(posedge clk);
      mem_lost <= 1'b0;
      @(negedge clk);
      chk(64'(now), 64'h90010100000001);
      @(posedge clk);
      clk_present <= 1'b0;
      op(0, b, 0, 16'h000C);
      tally_and_finish();
   end
endmodule : tdc_clock_bench
`default_nettype wire
